// *** rtl/afecw_regs.svh ***
/*
 * Register indices, field positions, reset values and counts of the
 * front end control word register bank.
 * Assumes it is included by bare name by the package-using design files.
 */
`ifndef AFECW_REGS_SVH
`define AFECW_REGS_SVH

// Register indices (3-bit register address field)
`define AFECW_IDX_MODE 3'h0
`define AFECW_IDX_CLK 3'h1
`define AFECW_IDX_PWR 3'h2
`define AFECW_IDX_PAIR12 3'h3
`define AFECW_IDX_PAIR34 3'h4
`define AFECW_IDX_PAIR56 3'h5
`define AFECW_IDX_SEL 3'h6
`define AFECW_IDX_TEST 3'h7
`define AFECW_REG_RESET 8'h00

// Control word fields
`define AFECW_CW_CTRL 15
`define AFECW_CW_RW 14
`define AFECW_CW_DEV_LSB 11
`define AFECW_CW_REG_LSB 8

// Mode and cascade register fields
`define AFECW_MODE_OPBIT 0
`define AFECW_MODE_MIXED 1
`define AFECW_MODE_LOOP 3
`define AFECW_MODE_CASC_LSB 4
`define AFECW_MODE_SWRST 7

// Clock rate register fields
`define AFECW_CLK_DEC_LSB 0
`define AFECW_CLK_BDIV_LSB 2
`define AFECW_CLK_MDIV_LSB 4
`define AFECW_CLK_ECHO 7

// Power, reference and selection fields
`define AFECW_PWR_GLOBAL 0
`define AFECW_PWR_REF 5
`define AFECW_PWR_PIN 6
`define AFECW_SEL_MODRST 6
`define AFECW_SEL_SE 7

// Counts
`define AFECW_SWRST_TICKS 3'h4
`define AFECW_MDIV_MAX 3'h4
`define AFECW_BDIV_BASE 4'h8
`define AFECW_DEC_BASE 12'h800
`define AFECW_BIT_LAST 4'hf

`endif

// *** rtl/afecw_pkg.sv ***
/*
 * Types of the front end control word register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package afecw_pkg;

    // Serial input framing states
    typedef enum logic [1:0] {IN_IDLE = 2'b01, IN_SHIFT = 2'b10} afecw_in_st_t;

    // Serial output framing states
    typedef enum logic [2:0] {OUT_IDLE = 3'b001, OUT_SYNC = 3'b010, OUT_SHIFT = 3'b100} afecw_out_st_t;

    // Whole state of the bank
    typedef struct packed {
        logic [7:0][7:0] regs;
        afecw_in_st_t in_st;
        logic [15:0] in_sh;
        logic [3:0] in_cnt;
        afecw_out_st_t out_st;
        logic [15:0] out_sh;
        logic [3:0] out_cnt;
        logic sdo;
        logic sdofs;
        logic sclk;
        logic samp_pend;
        logic [15:0] samp_word;
        logic pend_vld;
        logic [15:0] pend_word;
        logic [2:0] swrst_cnt;
        logic swrst_busy;
    } afecw_state_t;

endpackage

// *** rtl/afecw_sync2.sv ***
/*
 * Two flip-flop synchroniser for pin inputs.
 * Assumes the output is the only signal read by other logic.
 */
`timescale 1ns/1ps
`default_nettype none

module afecw_sync2 #(
    parameter int W = 1
) (
    input wire logic i_clk, // Clock
    input wire logic i_arst_n, // Async reset, active low
    input wire logic [W-1:0] i_d, // Asynchronous input
    output logic [W-1:0] o_q // Synchronised output
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } afecw_sync_t;

    afecw_sync_t cur;
    afecw_sync_t nxt;

    // Two stages, first read only by second
    always_comb
    begin
        nxt = cur;
        nxt.s1 = i_d;
        nxt.s2 = cur.s1;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            cur <= '0;
        else
            cur <= nxt;
    end

    assign o_q = cur.s2;
endmodule

`default_nettype wire

// *** rtl/afecw_clkdiv.sv ***
/*
 * Programmable divider producing one-cycle enable pulses.
 * Assumes i_ratio is at least one and i_tick is a one-cycle enable.
 */
`timescale 1ns/1ps
`default_nettype none

module afecw_clkdiv #(
    parameter int W = 4
) (
    input wire logic i_clk, // Clock
    input wire logic i_arst_n, // Async reset, active low
    input wire logic i_tick, // Input rate enable
    input wire logic [W-1:0] i_ratio, // Divide ratio
    output logic o_pulse // Divided enable pulse
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic pulse;
    } afecw_div_t;

    afecw_div_t cur;
    afecw_div_t nxt;

    // Count input ticks, pulse on the last
    always_comb
    begin
        nxt = cur;
        nxt.pulse = 1'b0;
        if (i_tick)
        begin
            if (cur.cnt >= i_ratio - W'(1))
            begin
                nxt.cnt = '0;
                nxt.pulse = 1'b1;
            end
            else
                nxt.cnt = cur.cnt + W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            cur <= '0;
        else
            cur <= nxt;
    end

    assign o_pulse = cur.pulse;
endmodule

`default_nettype wire

// *** rtl/afecw_bank.sv ***
/*
 * Control word register bank of the analog front end serial port:
 * word decode, eight control registers, cascade forwarding, read back,
 * software reset and the clock dividers that pace the serial port.
 * Assumes the master clock input is I_CLK itself and that the serial
 * input pins are asynchronous to it; the ADC word is on I_CLK.
 */
//
// Behaviour
// - Bit 15 marks a control word.
// - Write stores data into the addressed register.
// - Read returns register data in outgoing word.
// - Nonzero device address decremented and forwarded.
// - Register address field selects one of eight.
// - Low byte is data when address zero.
// - Mode bit zero program, one data.
// - Mode register bit one enables mixed mode.
// - Loop-back bit returns received words unchanged.
// - Mode bits four to six cascade count.
// - Writing reset bit starts software reset.
// - Clock register bits 0-1 decimation code.
// - Clock register bits 2-3 serial divider code.
// - Clock register bits 4-6 master divider code.
// - Clock register bit seven enables echo.
// - Power bit zero is global power-up.
// - Power bit five powers the reference.
// - Power bit six enables reference pin.
// - Pair registers hold gain and power.
// - Select bits choose channels, bit six resets modulator.
// - Select bit seven enables single-ended inputs.
// - Master divider ratio code plus one, else one.
// - Serial divider eight, four, two, one.
// - Decimation 2048, 1024, 512, 256.
// - Mixed mode MSB flags control versus data.
`timescale 1ns/1ps
`default_nettype none
`include "afecw_regs.svh"

module afecw_bank (
    input wire logic I_CLK, // 20 MHz master clock input
    input wire logic I_ARST_N, // Async reset, active low
    input wire logic I_SDI, // Serial data in pin
    input wire logic I_SDIFS, // Serial input frame sync pin
    input wire logic [15:0] I_ADC_WORD, // Latest converter word
    output logic O_SCLK, // Serial clock pin
    output logic O_SDO, // Serial data out pin
    output logic O_SDOFS, // Serial output frame sync pin
    output logic O_SAMPLE_TICK, // Sample rate enable pulse
    output logic O_SOFT_RESET, // Software reset in progress
    output logic O_OPERATING_MODE_BIT, // 0 program, 1 data
    output logic O_MIXED_MODE_ENABLE, // Mixed mode on
    output logic [2:0] O_CASCADE_COUNT, // Devices in cascade
    output logic O_GLOBAL_POWER_UP, // Global power control
    output logic O_REFERENCE_POWER, // Reference powered
    output logic O_REFERENCE_PIN_ENABLE, // Reference pin driven
    output logic [17:0] O_ADC_GAIN_CODE, // Gain codes, 3 bits per channel
    output logic [5:0] O_ADC_POWER_ON, // Channel power, 1 = on
    output logic [5:0] O_ADC_PATH_ENABLE, // Channel select
    output logic O_MODULATOR_RESET, // Modulator reset
    output logic O_SINGLE_ENDED_INPUT_ENABLE, // Single-ended inputs
    output logic [7:0] O_TEST_INVERT_REG // Test and invert register
);
    ////////////////////////////////////////////////////////////////////
    // Declarations

    afecw_pkg::afecw_state_t cur;
    afecw_pkg::afecw_state_t nxt;
    logic sdi_s;
    logic sdifs_s;
    logic imclk_en;
    logic sclk_en;
    logic sample_en;
    logic bit_en;
    logic word_done;
    logic [15:0] word;
    logic op_mode;
    logic mixed;
    logic loopback;
    logic take;
    logic [2:0] dev_addr;
    logic [2:0] reg_addr;
    logic [7:0] rd_data;
    logic [7:0] clk_reg;

    // Master divider ratio from its code
    function automatic logic [2:0] mdiv_ratio(input logic [2:0] code);
        if (code <= `AFECW_MDIV_MAX)
            mdiv_ratio = code + 3'h1;
        else
            mdiv_ratio = 3'h1;
    endfunction

    // Serial clock divider ratio from its code
    function automatic logic [3:0] bdiv_ratio(input logic [1:0] code);
        bdiv_ratio = `AFECW_BDIV_BASE >> code;
    endfunction

    // Decimation ratio from its code
    function automatic logic [11:0] dec_ratio(input logic [1:0] code);
        dec_ratio = `AFECW_DEC_BASE >> code;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and rate dividers

    afecw_sync2 #(.W(2)) u_sync (
        .i_clk(I_CLK),
        .i_arst_n(I_ARST_N),
        .i_d({I_SDIFS, I_SDI}),
        .o_q({sdifs_s, sdi_s})
    );

    assign clk_reg = cur.regs[`AFECW_IDX_CLK];

    // Internal master clock from master clock input
    afecw_clkdiv #(.W(3)) u_mclk (
        .i_clk(I_CLK),
        .i_arst_n(I_ARST_N),
        .i_tick(1'b1),
        .i_ratio(mdiv_ratio(clk_reg[`AFECW_CLK_MDIV_LSB +: 3])),
        .o_pulse(imclk_en)
    );

    // Serial clock from internal master clock
    afecw_clkdiv #(.W(4)) u_sclk (
        .i_clk(I_CLK),
        .i_arst_n(I_ARST_N),
        .i_tick(imclk_en),
        .i_ratio(bdiv_ratio(clk_reg[`AFECW_CLK_BDIV_LSB +: 2])),
        .o_pulse(sclk_en)
    );

    // Sample rate from internal master clock
    afecw_clkdiv #(.W(12)) u_samp (
        .i_clk(I_CLK),
        .i_arst_n(I_ARST_N),
        .i_tick(imclk_en),
        .i_ratio(dec_ratio(clk_reg[`AFECW_CLK_DEC_LSB +: 2])),
        .o_pulse(sample_en)
    );

    ////////////////////////////////////////////////////////////////////
    // Word decode helpers

    assign bit_en = sclk_en & cur.sclk;
    assign op_mode = cur.regs[`AFECW_IDX_MODE][`AFECW_MODE_OPBIT];
    assign mixed = cur.regs[`AFECW_IDX_MODE][`AFECW_MODE_MIXED];
    assign loopback = cur.regs[`AFECW_IDX_MODE][`AFECW_MODE_LOOP];
    assign dev_addr = word[`AFECW_CW_DEV_LSB +: 3];
    assign reg_addr = word[`AFECW_CW_REG_LSB +: 3];
    assign rd_data = cur.regs[reg_addr];
    // Control flag; data mode without mixed ignores input
    assign take = word_done & !cur.swrst_busy & !loopback & word[`AFECW_CW_CTRL] & (!op_mode | mixed);

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        nxt = cur;
        word_done = 1'b0;
        word = '0;

        // Serial clock pin toggles at each serial enable
        if (sclk_en)
            nxt.sclk = ~cur.sclk;

        // Input framing, bits taken on falling serial clock
        case (cur.in_st)
            afecw_pkg::IN_IDLE:
            begin
                if (bit_en && sdifs_s)
                begin
                    nxt.in_st = afecw_pkg::IN_SHIFT;
                    nxt.in_cnt = '0;
                end
            end
            afecw_pkg::IN_SHIFT:
            begin
                if (bit_en)
                begin
                    nxt.in_sh = {cur.in_sh[14:0], sdi_s};
                    nxt.in_cnt = cur.in_cnt + 4'h1;
                    if (cur.in_cnt == `AFECW_BIT_LAST)
                    begin
                        word_done = 1'b1;
                        word = {cur.in_sh[14:0], sdi_s};
                        nxt.in_cnt = '0;
                        nxt.in_st = sdifs_s ? afecw_pkg::IN_SHIFT : afecw_pkg::IN_IDLE;
                    end
                end
            end
            default:
                nxt.in_st = afecw_pkg::IN_IDLE;
        endcase

        // Output framing, sample event ahead of replies
        case (cur.out_st)
            afecw_pkg::OUT_IDLE:
            begin
                if (bit_en && (cur.samp_pend || cur.pend_vld))
                begin
                    nxt.sdofs = 1'b1;
                    nxt.out_st = afecw_pkg::OUT_SYNC;
                    if (cur.samp_pend)
                    begin
                        nxt.out_sh = cur.samp_word;
                        nxt.samp_pend = 1'b0;
                    end
                    else
                    begin
                        nxt.out_sh = cur.pend_word;
                        nxt.pend_vld = 1'b0;
                    end
                end
            end
            afecw_pkg::OUT_SYNC:
            begin
                if (bit_en)
                begin
                    nxt.sdofs = 1'b0;
                    nxt.sdo = cur.out_sh[15];
                    nxt.out_cnt = '0;
                    nxt.out_st = afecw_pkg::OUT_SHIFT;
                end
            end
            afecw_pkg::OUT_SHIFT:
            begin
                if (bit_en)
                begin
                    if (cur.out_cnt == `AFECW_BIT_LAST)
                    begin
                        nxt.sdo = 1'b0;
                        nxt.out_st = afecw_pkg::OUT_IDLE;
                    end
                    else
                    begin
                        nxt.out_sh = {cur.out_sh[14:0], 1'b0};
                        nxt.sdo = cur.out_sh[14];
                        nxt.out_cnt = cur.out_cnt + 4'h1;
                    end
                end
            end
            default:
                nxt.out_st = afecw_pkg::OUT_IDLE;
        endcase

        // Sample event, set wins over the load above
        if (sample_en)
        begin
            nxt.samp_pend = 1'b1;
            nxt.samp_word = I_ADC_WORD;
            if (op_mode && mixed)
                nxt.samp_word[15] = 1'b0;
        end

        // Loop-back returns the word untouched
        if (word_done && loopback && !cur.swrst_busy)
        begin
            nxt.pend_vld = 1'b1;
            nxt.pend_word = word;
        end

        // Accepted control word
        if (take)
        begin
            if (dev_addr != 3'h0)
            begin
                nxt.pend_vld = 1'b1;
                nxt.pend_word = word;
                nxt.pend_word[`AFECW_CW_DEV_LSB +: 3] = dev_addr - 3'h1;
            end
            else if (word[`AFECW_CW_RW])
            begin
                nxt.pend_vld = 1'b1;
                nxt.pend_word = {word[15:8], rd_data};
            end
            else
            begin
                nxt.regs[reg_addr] = word[7:0];
                if (cur.regs[`AFECW_IDX_CLK][`AFECW_CLK_ECHO])
                begin
                    nxt.pend_vld = 1'b1;
                    nxt.pend_word = word;
                end
                if (reg_addr == `AFECW_IDX_MODE && word[`AFECW_MODE_SWRST])
                begin
                    nxt.regs = '0;
                    nxt.swrst_cnt = `AFECW_SWRST_TICKS;
                end
            end
        end

        // Software reset lasts four internal master clock ticks
        if (cur.swrst_cnt != 3'h0 && imclk_en)
            nxt.swrst_cnt = cur.swrst_cnt - 3'h1;
        nxt.swrst_busy = (nxt.swrst_cnt != 3'h0);
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            cur <= '0;
            cur.in_st <= afecw_pkg::IN_IDLE;
            cur.out_st <= afecw_pkg::OUT_IDLE;
        end
        else
            cur <= nxt;
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops

    assign O_SCLK = cur.sclk;
    assign O_SDO = cur.sdo;
    assign O_SDOFS = cur.sdofs;
    assign O_SAMPLE_TICK = sample_en;
    assign O_SOFT_RESET = cur.swrst_busy;
    assign O_OPERATING_MODE_BIT = op_mode;
    assign O_MIXED_MODE_ENABLE = mixed;
    assign O_CASCADE_COUNT = cur.regs[`AFECW_IDX_MODE][`AFECW_MODE_CASC_LSB +: 3];
    assign O_GLOBAL_POWER_UP = cur.regs[`AFECW_IDX_PWR][`AFECW_PWR_GLOBAL];
    assign O_REFERENCE_POWER = cur.regs[`AFECW_IDX_PWR][`AFECW_PWR_REF];
    assign O_REFERENCE_PIN_ENABLE = cur.regs[`AFECW_IDX_PWR][`AFECW_PWR_PIN];
    assign O_ADC_PATH_ENABLE = cur.regs[`AFECW_IDX_SEL][5:0];
    assign O_MODULATOR_RESET = cur.regs[`AFECW_IDX_SEL][`AFECW_SEL_MODRST];
    assign O_SINGLE_ENDED_INPUT_ENABLE = cur.regs[`AFECW_IDX_SEL][`AFECW_SEL_SE];
    assign O_TEST_INVERT_REG = cur.regs[`AFECW_IDX_TEST];

    // Per channel gain and power from the pair registers
    for (genvar g = 0; g < 6; g++)
    begin : g_chan
        assign O_ADC_GAIN_CODE[3*g +: 3] = cur.regs[3 + g/2][4*(g%2) +: 3];
        assign O_ADC_POWER_ON[g] = cur.regs[3 + g/2][4*(g%2) + 3];
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions

    a_write_store: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        take && dev_addr == 3'h0 && !word[`AFECW_CW_RW] && reg_addr != `AFECW_IDX_MODE
        |=> cur.regs[$past(reg_addr)] == $past(word[7:0]))
        else $error("write did not store data");

    a_read_reply: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        take && dev_addr == 3'h0 && word[`AFECW_CW_RW]
        |=> cur.pend_vld && cur.pend_word == {$past(word[15:8]), $past(rd_data)})
        else $error("read reply wrong");

    a_forward_dec: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        take && dev_addr != 3'h0
        |=> cur.pend_word[13:11] == $past(dev_addr) - 3'h1 && $stable(cur.regs))
        else $error("forwarded address not decremented");

    a_data_ignore: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        word_done && op_mode && !mixed && !cur.swrst_busy |=> $stable(cur.regs))
        else $error("data mode changed registers");

    a_flag_clear: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        word_done && !word[`AFECW_CW_CTRL] && !cur.swrst_busy |=> $stable(cur.regs))
        else $error("word without control flag acted on");

    a_soft_reset: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        take && dev_addr == 3'h0 && !word[`AFECW_CW_RW] && reg_addr == `AFECW_IDX_MODE && word[7]
        |=> cur.regs == '0 && cur.swrst_busy && cur.swrst_cnt == 3'h4)
        else $error("software reset not started");

    a_sample_flag: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        sample_en && op_mode && mixed |=> cur.samp_pend && !cur.samp_word[15])
        else $error("mixed mode sample flag set");

    a_loopback: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        word_done && loopback && !cur.swrst_busy |=> cur.pend_vld && cur.pend_word == $past(word))
        else $error("loop-back word altered");

    a_echo_write: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        take && dev_addr == 3'h0 && !word[`AFECW_CW_RW] && clk_reg[`AFECW_CLK_ECHO]
        |=> cur.pend_vld && cur.pend_word == $past(word))
        else $error("write not echoed");
endmodule

`default_nettype wire

// *** verification/afecw_host_model.sv ***
/*
 * Serial host model: sends control words, collects output words.
 * Assumes the bank's serial half period exceeds its input sync delay.
 */
`timescale 1ns/1ps
`default_nettype none

module afecw_host_model (
    input wire logic i_clk, // Bank clock
    input wire logic i_sclk, // Serial clock pin
    input wire logic i_sdo, // Serial data out pin
    input wire logic i_sdofs, // Output frame sync pin
    output logic o_sdi, // Serial data to bank
    output logic o_sdifs // Input frame sync to bank
);
    logic busy = 1'b0;
    logic [15:0] rx_sh = 16'h0000;
    int rx_cnt = 0;
    logic [15:0] rx_q[$];

    initial
    begin
        o_sdi = 1'b0;
        o_sdifs = 1'b0;
    end

    // Idle data line toggles so no stale bit survives
    always @(posedge i_clk)
    begin
        if (!busy)
            o_sdi <= ~o_sdi;
    end

    // Sync one bit early, then sixteen bits MSB first, held to the fall
    task automatic send(input logic [15:0] w);
        busy = 1'b1;
        for (int i = 16; i >= 0; i--)
        begin
            @(posedge i_sclk);
            @(posedge i_clk);
            o_sdifs <= (i == 16);
            o_sdi <= (i < 16) ? w[i] : 1'b0;
        end
        @(negedge i_sclk);
        repeat (4) @(posedge i_clk);
        busy = 1'b0;
    endtask

    // Output words sampled mid-bit on the rising serial clock
    always @(posedge i_sclk)
    begin
        if (rx_cnt != 0)
        begin
            rx_sh = {rx_sh[14:0], i_sdo};
            rx_cnt = rx_cnt - 1;
            if (rx_cnt == 0)
                rx_q.push_back(rx_sh);
        end
        else if (i_sdofs === 1'b1)
            rx_cnt = 16;
    end
endmodule

`default_nettype wire

// *** verification/testbench.sv ***
/*
 * Bench of the control word register bank over its serial port.
 * Assumes the host model drives the serial inputs; master clock is I_CLK.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic I_CLK = 1'b0;
    logic I_ARST_N = 1'b0;
    logic [15:0] I_ADC_WORD = 16'hdaa5;
    logic sdi, sdifs, sclk, sdo, sdofs, tick, srst, opm, mix, gpw, refp, pin, modr, se;
    logic [2:0] casc;
    logic [17:0] gain;
    logic [5:0] pon, path;
    logic [7:0] tst;
    logic [7:0] exp_r [8] = '{default: 8'h00};
    logic sr_single_ended_input_enable = 1'b0;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;

    afecw_bank dut (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_SDI(sdi), .I_SDIFS(sdifs),
        .I_ADC_WORD(I_ADC_WORD), .O_SCLK(sclk), .O_SDO(sdo), .O_SDOFS(sdofs), .O_SAMPLE_TICK(tick),
        .O_SOFT_RESET(srst), .O_OPERATING_MODE_BIT(opm), .O_MIXED_MODE_ENABLE(mix),
        .O_CASCADE_COUNT(casc), .O_GLOBAL_POWER_UP(gpw), .O_REFERENCE_POWER(refp),
        .O_REFERENCE_PIN_ENABLE(pin), .O_ADC_GAIN_CODE(gain), .O_ADC_POWER_ON(pon),
        .O_ADC_PATH_ENABLE(path), .O_MODULATOR_RESET(modr), .O_SINGLE_ENDED_INPUT_ENABLE(se),
        .O_TEST_INVERT_REG(tst));
    afecw_host_model host (.i_clk(I_CLK), .i_sclk(sclk), .i_sdo(sdo), .i_sdofs(sdofs),
        .o_sdi(sdi), .o_sdifs(sdifs));

    // Clock, cycle ceiling and soft reset watch
    initial
    begin
        forever #25 I_CLK = ~I_CLK;
    end
    always @(posedge I_CLK)
    begin
        cyc++;
        if (srst === 1'b1)
            sr_single_ended_input_enable <= 1'b1;
        if (cyc == 100000)
        begin
            err_total++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [47:0] obs();
        return {opm, mix, casc, gpw, refp, pin, gain, pon, path, modr, se, tst};
    endfunction

    // Port levels predicted from the expected register contents
    function automatic logic [47:0] exp_obs();
        logic [17:0] g;
        logic [5:0] p;
        for (int k = 0; k < 3; k++)
        begin
            g[6*k +: 3] = exp_r[3+k][2:0];
            g[6*k+3 +: 3] = exp_r[3+k][6:4];
            p[2*k] = exp_r[3+k][3];
            p[2*k+1] = exp_r[3+k][7];
        end
        return {exp_r[0][0], exp_r[0][1], exp_r[0][6:4], exp_r[2][0], exp_r[2][5], exp_r[2][6],
            g, p, exp_r[6][5:0], exp_r[6][6], exp_r[6][7], exp_r[7]};
    endfunction

    task automatic check(input string what, input logic [47:0] single_ended_input_enable, input logic [47:0] exp);
        checks_done++;
        if (single_ended_input_enable !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h single_ended_input_enable %h", what, exp, single_ended_input_enable);
        end
    endtask

    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        exp_r[idx] = d;
        host.send({5'h10, idx, d});
    endtask

    // Next output word; sample words skipped unless raw
    task automatic get_reply(input logic raw, output logic [15:0] w);
        int n;
        n = 0;
        w = 16'hxxxx;
        while (n < 20000)
        begin
            @(posedge I_CLK);
            n++;
            if (host.rx_q.size() > 0)
            begin
                w = host.rx_q.pop_front();
                if (raw || w[14:0] !== 15'h5aa5)
                    n = 20001;
            end
        end
        if (n == 20000)
            w = 16'hxxxx;
    endtask

    // Cycles between the second and third rise of tick or serial clock
    task automatic gap(input logic use_sclk, output int n);
        logic v, p;
        int k;
        p = 1'b1;
        k = 0;
        n = 0;
        while (k < 3)
        begin
            @(posedge I_CLK);
            v = use_sclk ? sclk : tick;
            if (v === 1'b1 && p !== 1'b1)
                k++;
            if (k == 2)
                n++;
            p = v;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [15:0] w;
        check("reset outputs", obs(), exp_obs());
        check("soft reset idle", srst, 1'b0);
        host.rx_q.delete();
        get_reply(1'b1, w);
        check("program sample", w, 16'hdaa5);
        $display("done reset");
    endtask

    task automatic t_write();
        logic [7:0] vals [6] = '{8'h61, 8'hab, 8'h5e, 8'h97, 8'hc5, 8'h5c};
        for (int i = 2; i < 8; i++)
        begin
            wr(3'(i), vals[i-2]);
            check("register write", obs(), exp_obs());
        end
        $display("done write");
    endtask

    task automatic t_read_fwd();
        logic [15:0] w;
        host.rx_q.delete();
        host.send(16'hc4ff);
        get_reply(1'b0, w);
        check("read reply", w, {8'hc4, exp_r[4]});
        host.send(16'h9a34);
        get_reply(1'b0, w);
        check("forward", w, 16'h9234);
        host.send(16'h0255);
        check("forward and refuse keep", obs(), exp_obs());
        $display("done read forward");
    endtask

    task automatic t_clock();
        logic [15:0] w;
        int n;
        wr(3'h1, 8'h81);
        host.rx_q.delete();
        wr(3'h1, 8'h81);
        get_reply(1'b0, w);
        check("echo", w, 16'h8181);
        gap(1'b0, n);
        check("sample period", n, 1024);
        wr(3'h1, 8'h20);
        gap(1'b0, n);
        check("divided sample period", n, 6144);
        gap(1'b1, n);
        check("slow serial period", n, 48);
        wr(3'h1, 8'h04);
        gap(1'b1, n);
        check("serial period", n, 8);
        wr(3'h1, 8'h00);
        check("clock outputs", obs(), exp_obs());
        $display("done clock");
    endtask

    task automatic t_mixed();
        logic [15:0] w;
        wr(3'h0, 8'h53);
        check("mode outputs", obs(), exp_obs());
        host.rx_q.delete();
        get_reply(1'b1, w); // May be a sample taken before the mode change
        get_reply(1'b1, w);
        check("mixed sample", w, 16'h5aa5);
        wr(3'h2, 8'h21);
        check("mixed write", obs(), exp_obs());
        wr(3'h0, 8'h01);
        host.send(16'h8233);
        check("data mode refuse", obs(), exp_obs());
        // Only a hardware reset leaves plain data mode
        I_ARST_N <= 1'b0;
        repeat (2) @(posedge I_CLK);
        I_ARST_N <= 1'b1;
        exp_r = '{default: 8'h00};
        repeat (2) @(posedge I_CLK);
        check("hard reset clears", obs(), exp_obs());
        $display("done mixed");
    endtask

    task automatic t_swrst_loop();
        logic [15:0] w;
        sr_single_ended_input_enable = 1'b0;
        wr(3'h0, 8'h80);
        repeat (20) @(posedge I_CLK);
        check("soft reset single_ended_input_enable", sr_single_ended_input_enable, 1'b1);
        check("soft reset over", srst, 1'b0);
        exp_r = '{default: 8'h00};
        check("soft reset clears", obs(), exp_obs());
        wr(3'h0, 8'h08);
        host.rx_q.delete();
        host.send(16'h8255);
        get_reply(1'b0, w);
        check("loop back", w, 16'h8255);
        check("loop back no decode", obs(), exp_obs());
        $display("done soft reset loop");
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (2) @(posedge I_CLK);
        I_ARST_N <= 1'b1;
        repeat (2) @(posedge I_CLK);
        t_reset();
        t_write();
        t_read_fwd();
        t_clock();
        t_mixed();
        t_swrst_loop();
        stop_test();
    end
endmodule

`default_nettype wire
